// ==== hbp_gate.sv ====
// per-bridge pwm gate decoder
`timescale 1ns/1ps
`default_nettype none
module hbp_gate #(
    parameter int unsigned BRIDGES  = 12,
    parameter int unsigned CHANNELS = 3
) (
    hbp_gate_if.gen g
);

    logic [CHANNELS-1:0] chan_on;

    // a stopped channel is held off, whatever its wave input does
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            assign chan_on[c] = g.wave[c] &&
                (g.freq_sel[2*c +: 2] != hbp_pkg::FREQ_STOPPED);
        end
    endgenerate

    function automatic logic gate_of(input logic [1:0] src,
                                     input logic [CHANNELS-1:0] on);
        logic r;
        r = 1'b1;
        case (hbp_pkg::hbp_src_t'(src))
            hbp_pkg::HBP_SRC_NONE: r = 1'b1;
            hbp_pkg::HBP_SRC_CH1:  r = on[0];
            hbp_pkg::HBP_SRC_CH2:  r = on[1];
            hbp_pkg::HBP_SRC_CH3:  r = on[2];
            default:               r = 1'b0;
        endcase
        return r;
    endfunction

    // no pwm: continuous; else follow the chosen channel
    genvar b;
    generate
        for (b = 0; b < BRIDGES; b++) begin : g_bridge
            assign g.gate[b] = gate_of(g.source[2*b +: 2], chan_on);
        end
    endgenerate

endmodule
`default_nettype wire

// ==== hbp_gate_if.sv ====
// carrier between the register logic and the pwm gate decoder
`timescale 1ns/1ps
`default_nettype none
interface hbp_gate_if #(
    parameter int unsigned BRIDGES  = 12,
    parameter int unsigned CHANNELS = 3
);
    logic [2*BRIDGES-1:0]  source;
    logic [CHANNELS-1:0]   wave;
    logic [2*CHANNELS-1:0] freq_sel;
    logic [BRIDGES-1:0]    gate;

    modport gen (
        input  source,
        input  wave,
        input  freq_sel,
        output gate
    );
    modport user (
        output source,
        output wave,
        output freq_sel,
        input  gate
    );
endinterface
`default_nettype wire

// ==== hbp_pkg.sv ====
// shared constants for the half-bridge enable and pwm-select block
package hbp_pkg;

    // spi command framing
    localparam int unsigned CMD_BITS       = 16;
    localparam int unsigned BYTE_BITS      = 8;
    localparam int unsigned CMD_WRITE_BIT  = 15;
    localparam int unsigned ADDR_FIELD_HI  = 14;
    localparam int unsigned ADDR_FIELD_LO  = 10;
    localparam logic [4:0]  CNT_ADDR_DONE  = 5'h08;
    localparam logic [4:0]  CNT_FRAME_DONE = 5'h10;

    // register select patterns, address byte bits 6:2
    localparam logic [4:0] ADDR_SWITCH_9_12 = 5'h08;
    localparam logic [4:0] ADDR_SELECT_1_4  = 5'h18;
    localparam logic [4:0] ADDR_SELECT_5_8  = 5'h04;

    // reset values
    localparam logic [7:0] RST_SWITCH_9_12 = 8'h00;
    localparam logic [7:0] RST_SELECT      = 8'h00;
    localparam logic [7:0] RST_STATUS      = 8'h00;

    // field layout
    localparam int unsigned SEL_FIELD_BITS  = 2;
    localparam int unsigned BRIDGES_PER_SEL = 4;
    localparam int unsigned UPPER_OFS       = 1;
    localparam int unsigned LOWER_OFS       = 0;
    localparam int unsigned STATUS_ERR_BIT  = 0;

    // pwm source codes
    typedef enum logic [1:0] {
        HBP_SRC_NONE = 2'h0,
        HBP_SRC_CH1  = 2'h1,
        HBP_SRC_CH2  = 2'h2,
        HBP_SRC_CH3  = 2'h3
    } hbp_src_t;

    // channel frequency select code meaning stopped
    localparam logic [1:0] FREQ_STOPPED = 2'h0;

    // frame state, one-hot
    typedef enum logic [3:0] {
        HBP_ST_IDLE = 4'h1,
        HBP_ST_ADDR = 4'h2,
        HBP_ST_DATA = 4'h4,
        HBP_ST_OVER = 4'h8
    } hbp_state_t;

endpackage

// ==== hbp_spi_master.sv ====
// spi master model standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module hbp_spi_master (
    // clock
    input  wire logic clock_i,
    // spi pins
    output var logic  spi_sclk_o,
    output var logic  spi_cs_n_o,
    output var logic  spi_sdi_o,
    input  wire logic spi_sdo_i
);
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_sdi_o  = 1'b0;
    end
    // n other than 16 is a deliberate framing fault
    task automatic frame(input logic [15:0] cmd, input int n,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clock_i);
        spi_cs_n_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            spi_sdi_o <= cmd[15-i];
            @(posedge clock_i);
            rx = {rx[14:0], spi_sdo_i};
            spi_sclk_o <= 1'b1;
            repeat (2) @(posedge clock_i);
            spi_sclk_o <= 1'b0;
        end
        repeat (2) @(posedge clock_i);
        spi_cs_n_o <= 1'b1;
        // released line shows no stale bit
        spi_sdi_o  <= ~spi_sdi_o;
        repeat (3) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// ==== hbp_top.sv ====
// half-bridge switch enables, pwm source selects and spi register access
`timescale 1ns/1ps
`default_nettype none
module hbp_top #(
    parameter int unsigned CHANNELS = 3
) (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  reset_n_i,
    // spi pins, synchronous to clock_i
    input  wire logic                  spi_sclk_i,
    input  wire logic                  spi_cs_n_i,
    input  wire logic                  spi_sdi_i,
    output logic                       spi_sdo_o,
    output logic                       spi_sdo_oe_n_o,
    // pwm channels and selects held elsewhere
    input  wire logic [CHANNELS-1:0]   pwm_wave_i,
    input  wire logic [2*CHANNELS-1:0] pwm_freq_sel_i,
    input  wire logic [7:0]            bridge9_12_pwm_source_i,
    // bridge 9..12 switch drives
    output logic [3:0]                 upper_switch_o,
    output logic [3:0]                 lower_switch_o,
    // pwm gate for bridges 1..8
    output logic [7:0]                 pwm_gate_o,
    // register contents
    output logic [7:0]                 switch_enable_o,
    output logic [7:0]                 select_1_4_o,
    output logic [7:0]                 select_5_8_o
);

    localparam int unsigned BRIDGES = 12;

    // register file
    logic [7:0] bridge_switch_enable_9_12_q;
    logic [7:0] bridge_pwm_select_1_4_q;
    logic [7:0] bridge_pwm_select_5_8_q;
    logic [7:0] status_q;

    // spi front end
    logic                  sclk_q;
    logic                  cs_n_q;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    hbp_pkg::hbp_state_t   state_q;
    hbp_pkg::hbp_state_t   state_d;
    logic [4:0]            bit_cnt_q;
    logic [hbp_pkg::CMD_BITS-1:0] in_sr_q;
    logic [hbp_pkg::CMD_BITS-1:0] in_next;
    logic [7:0]            out_sr_q;
    logic                  sdo_q;
    logic                  sdo_oe_n_q;
    logic                  frame_ok;
    logic                  do_write;
    logic [4:0]            wr_addr;
    logic [7:0]            wr_data;
    logic [7:0]            rd_data;

    // output stage
    logic [3:0]            upper_q;
    logic [3:0]            lower_q;
    logic [7:0]            gate_1_8_q;

    hbp_gate_if #(.BRIDGES(BRIDGES), .CHANNELS(CHANNELS)) gif ();

    // register select pattern, used by the read path; the write path slices in_sr_q directly
    function automatic logic [4:0] addr_of(input logic [7:0] abyte);
        return abyte[6:2];
    endfunction

    function automatic logic [7:0] read_mux(input logic [4:0] a,
                                            input logic [7:0] sw,
                                            input logic [7:0] s14,
                                            input logic [7:0] s58);
        logic [7:0] r;
        r = 8'h00;
        if (a == hbp_pkg::ADDR_SWITCH_9_12) begin
            r = sw;
        end else if (a == hbp_pkg::ADDR_SELECT_1_4) begin
            r = s14;
        end else if (a == hbp_pkg::ADDR_SELECT_5_8) begin
            r = s58;
        end else begin
            r = 8'h00;
        end
        return r;
    endfunction

    // pin sampling; inputs are already synchronous, one stage for edges
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= spi_sclk_i;
            cs_n_q <= spi_cs_n_i;
        end
    end

    assign sclk_rise = spi_sclk_i && !sclk_q && !spi_cs_n_i;
    assign sclk_fall = !spi_sclk_i && sclk_q && !spi_cs_n_i;
    assign cs_fall   = !spi_cs_n_i && cs_n_q;
    assign cs_rise   = spi_cs_n_i && !cs_n_q;
    assign in_next   = {in_sr_q[hbp_pkg::CMD_BITS-2:0], spi_sdi_i};

    // frame state
    always_comb begin
        state_d = state_q;
        case (state_q)
            hbp_pkg::HBP_ST_IDLE: begin
                if (cs_fall) begin
                    state_d = hbp_pkg::HBP_ST_ADDR;
                end
            end
            hbp_pkg::HBP_ST_ADDR: begin
                if (cs_rise) begin
                    state_d = hbp_pkg::HBP_ST_IDLE;
                end else if (sclk_rise &&
                             bit_cnt_q == hbp_pkg::CNT_ADDR_DONE - 5'h01) begin
                    state_d = hbp_pkg::HBP_ST_DATA;
                end
            end
            hbp_pkg::HBP_ST_DATA: begin
                if (cs_rise) begin
                    state_d = hbp_pkg::HBP_ST_IDLE;
                end else if (sclk_rise &&
                             bit_cnt_q == hbp_pkg::CNT_FRAME_DONE) begin
                    state_d = hbp_pkg::HBP_ST_OVER;
                end
            end
            hbp_pkg::HBP_ST_OVER: begin
                if (cs_rise) begin
                    state_d = hbp_pkg::HBP_ST_IDLE;
                end
            end
            default: state_d = hbp_pkg::HBP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= hbp_pkg::HBP_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bit counter and input shifter; saturates so long frames stay invalid
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt_q <= 5'h00;
            in_sr_q   <= '0;
        end else if (cs_fall) begin
            bit_cnt_q <= 5'h00;
            in_sr_q   <= '0;
        end else if (sclk_rise) begin
            in_sr_q <= in_next;
            if (bit_cnt_q != 5'h1f) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // a frame counts only with exactly sixteen clocks
    assign frame_ok = cs_rise && (state_q == hbp_pkg::HBP_ST_DATA) &&
                      (bit_cnt_q == hbp_pkg::CNT_FRAME_DONE);
    assign do_write = frame_ok && in_sr_q[hbp_pkg::CMD_WRITE_BIT];
    assign wr_addr  = in_sr_q[hbp_pkg::ADDR_FIELD_HI:hbp_pkg::ADDR_FIELD_LO];
    assign wr_data  = in_sr_q[hbp_pkg::BYTE_BITS-1:0];

    // registers change only on a valid write frame
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bridge_switch_enable_9_12_q <= hbp_pkg::RST_SWITCH_9_12;
        end else if (do_write && wr_addr == hbp_pkg::ADDR_SWITCH_9_12) begin
            bridge_switch_enable_9_12_q <= wr_data;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bridge_pwm_select_1_4_q <= hbp_pkg::RST_SELECT;
        end else if (do_write && wr_addr == hbp_pkg::ADDR_SELECT_1_4) begin
            bridge_pwm_select_1_4_q <= wr_data;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bridge_pwm_select_5_8_q <= hbp_pkg::RST_SELECT;
        end else if (do_write && wr_addr == hbp_pkg::ADDR_SELECT_5_8) begin
            bridge_pwm_select_5_8_q <= wr_data;
        end
    end

    // status: bit 0 flags the last frame as malformed
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_q <= hbp_pkg::RST_STATUS;
        end else if (cs_rise) begin
            status_q[hbp_pkg::STATUS_ERR_BIT] <= !frame_ok;
        end
    end

    assign rd_data = read_mux(addr_of(in_next[7:0]),
                              bridge_switch_enable_9_12_q,
                              bridge_pwm_select_1_4_q,
                              bridge_pwm_select_5_8_q);

    // in-frame answer: status during address byte, register during data
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_sr_q   <= 8'h00;
            sdo_q      <= 1'b0;
            sdo_oe_n_q <= 1'b1;
        end else if (cs_fall) begin
            out_sr_q   <= {status_q[6:0], 1'b0};
            sdo_q      <= status_q[7];
            sdo_oe_n_q <= 1'b0;
        end else if (cs_rise) begin
            sdo_q      <= 1'b0;
            sdo_oe_n_q <= 1'b1;
        end else if (sclk_rise &&
                     bit_cnt_q == hbp_pkg::CNT_ADDR_DONE - 5'h01) begin
            out_sr_q <= rd_data;
        end else if (sclk_fall) begin
            sdo_q    <= out_sr_q[7];
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
    end

    // gate decoder hookup
    assign gif.source   = {bridge9_12_pwm_source_i,
                           bridge_pwm_select_5_8_q,
                           bridge_pwm_select_1_4_q};
    assign gif.wave     = pwm_wave_i;
    assign gif.freq_sel = pwm_freq_sel_i;

    hbp_gate #(
        .BRIDGES  (BRIDGES),
        .CHANNELS (CHANNELS)
    ) u_gate (
        .g (gif.gen)
    );

    // switch drive with cross-current interlock for bridges 9..12
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_drive
            logic up_en;
            logic lo_en;
            assign up_en = bridge_switch_enable_9_12_q[
                2*k + hbp_pkg::UPPER_OFS];
            assign lo_en = bridge_switch_enable_9_12_q[
                2*k + hbp_pkg::LOWER_OFS];
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    upper_q[k] <= 1'b0;
                    lower_q[k] <= 1'b0;
                end else begin
                    upper_q[k] <= up_en && !lo_en &&
                                  gif.gate[8+k];
                    lower_q[k] <= lo_en && !up_en &&
                                  gif.gate[8+k];
                end
            end
        end
    endgenerate

    // gate for bridges 1..8, whose enables live elsewhere
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gate_1_8_q <= 8'h00;
        end else begin
            gate_1_8_q <= gif.gate[7:0];
        end
    end

    assign upper_switch_o  = upper_q;
    assign lower_switch_o  = lower_q;
    assign pwm_gate_o      = gate_1_8_q;
    assign spi_sdo_o       = sdo_q;
    assign spi_sdo_oe_n_o  = sdo_oe_n_q;
    assign switch_enable_o = bridge_switch_enable_9_12_q;
    assign select_1_4_o    = bridge_pwm_select_1_4_q;
    assign select_5_8_o    = bridge_pwm_select_5_8_q;

endmodule
`default_nettype wire

// ==== hbp_top_props.sv ====
// assertions on the ports of the half-bridge register block
`timescale 1ns/1ps
`default_nettype none
module hbp_top_props #(
    parameter int unsigned CHANNELS = 3
) (
    // watched top ports
    input wire logic                  clock_i,
    input wire logic                  reset_n_i,
    input wire logic                  spi_sclk_i,
    input wire logic                  spi_cs_n_i,
    input wire logic                  spi_sdi_i,
    input wire logic                  spi_sdo_o,
    input wire logic                  spi_sdo_oe_n_o,
    input wire logic [CHANNELS-1:0]   pwm_wave_i,
    input wire logic [2*CHANNELS-1:0] pwm_freq_sel_i,
    input wire logic [7:0]            bridge9_12_pwm_source_i,
    input wire logic [3:0]            upper_switch_o,
    input wire logic [3:0]            lower_switch_o,
    input wire logic [7:0]            pwm_gate_o,
    input wire logic [7:0]            switch_enable_o,
    input wire logic [7:0]            select_1_4_o,
    input wire logic [7:0]            select_5_8_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence bridge1_stopped_s;
        select_1_4_o[1:0] == 2'h1 && pwm_freq_sel_i[1:0] == 2'h0;
    endsequence
    sequence bridge1_free_s;
        select_1_4_o[1:0] == 2'h0;
    endsequence
    reset_clear_a: assert property (
        $rose(reset_n_i) |-> switch_enable_o == 8'h00 && upper_switch_o == 4'h0
        && select_1_4_o == 8'h00 && select_5_8_o == 8'h00)
        else $error("registers not clear after reset");
    for (genvar b = 0; b < 4; b++) begin : g_br
        upper_cause_a: assert property (
            upper_switch_o[b] |-> $past(switch_enable_o[2*b+1:2*b]) == 2'h2)
            else $error("upper switch on without its sole enable");
        lower_cause_a: assert property (
            lower_switch_o[b] |-> $past(switch_enable_o[2*b+1:2*b]) == 2'h1)
            else $error("lower switch on without its sole enable");
        cross_off_a: assert property (
            switch_enable_o[2*b+1:2*b] == 2'h3 [*2]
            |-> !upper_switch_o[b] && !lower_switch_o[b])
            else $error("both switches of a bridge not off");
        steady_on_a: assert property (
            (switch_enable_o[2*b+1:2*b] == 2'h2
            && bridge9_12_pwm_source_i[2*b+1:2*b] == 2'h0) [*3]
            |-> upper_switch_o[b])
            else $error("enabled switch without pwm not on");
    end
    stopped_off_a: assert property (
        bridge1_stopped_s [*3] |-> !pwm_gate_o[0])
        else $error("stopped channel still gates bridge 1");
    free_gate_a: assert property (
        bridge1_free_s [*3] |-> pwm_gate_o[0])
        else $error("bridge 1 without pwm not continuous");
    ctrl_hold_a: assert property (
        $changed({switch_enable_o, select_1_4_o, select_5_8_o})
        |-> spi_cs_n_i && (!$past(spi_cs_n_i, 2) || !$past(spi_cs_n_i, 3)))
        else $error("control bits changed outside a frame end");
    idle_quiet_a: assert property (
        spi_cs_n_i [*3] |-> spi_sdo_oe_n_o && !spi_sdo_o)
        else $error("serial output driven while deselected");
    frame_drive_a: assert property (
        $fell(spi_cs_n_i) |=> !spi_sdo_oe_n_o)
        else $error("serial output not driven in a frame");
endmodule
bind hbp_top hbp_top_props #(.CHANNELS(CHANNELS)) u_props (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_n_o(spi_sdo_oe_n_o), .pwm_wave_i(pwm_wave_i),
    .pwm_freq_sel_i(pwm_freq_sel_i),
    .bridge9_12_pwm_source_i(bridge9_12_pwm_source_i),
    .upper_switch_o(upper_switch_o), .lower_switch_o(lower_switch_o),
    .pwm_gate_o(pwm_gate_o), .switch_enable_o(switch_enable_o),
    .select_1_4_o(select_1_4_o), .select_5_8_o(select_5_8_o));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the half-bridge register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock_i;
    logic        reset_n_i   = 1'b0;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic        oe_n;
    logic [2:0]  wave        = 3'h0;
    logic [5:0]  freq        = 6'h00;
    logic [7:0]  src912      = 8'h00;
    logic [3:0]  upper;
    logic [3:0]  lower;
    logic [7:0]  gate;
    logic [7:0]  sw_en;
    logic [7:0]  sel14;
    logic [7:0]  sel58;
    logic [15:0] rx;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    hbp_top #(.CHANNELS(3)) dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_n_o(oe_n), .pwm_wave_i(wave), .pwm_freq_sel_i(freq),
        .bridge9_12_pwm_source_i(src912), .upper_switch_o(upper),
        .lower_switch_o(lower), .pwm_gate_o(gate),
        .switch_enable_o(sw_en), .select_1_4_o(sel14),
        .select_5_8_o(sel58));
    hbp_spi_master master (
        .clock_i(clock_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
        .spi_sdi_o(sdi), .spi_sdo_i(sdo));
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // {lower, upper}: a bridge with both enables stays off
    function automatic logic [7:0] drive(input logic [7:0] en);
        for (int b = 0; b < 4; b++) begin
            drive[b]   = en[2*b+1] & ~en[2*b];
            drive[b+4] = en[2*b] & ~en[2*b+1];
        end
    endfunction
    function automatic logic gexp(input logic [1:0] s);
        return s == 2'h0 || (wave[s-2'h1] && freq[2*s-1 -: 2] != 2'h0);
    endfunction
    task automatic xfer(input logic w, input logic [4:0] pat,
                        input logic [7:0] d);
        master.frame({w, pat, 2'h0, d}, 16, rx);
        @(negedge clock_i);
    endtask
    task automatic t_reset;
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(negedge clock_i);
        check({oe_n, 7'h0, sw_en, sel14, sel58}, 32'h80000000);
        check({24'h0, upper, lower}, 32'h0);
    endtask
    task automatic t_enables;
        logic [7:0] v [4] = '{8'h99, 8'h66, 8'hff, 8'hc9};
        foreach (v[i]) begin
            xfer(1'b1, 5'h08, v[i]);
            check({16'h0, lower, upper, sw_en},
                  {16'h0, drive(v[i]), v[i]});
        end
    endtask
    task automatic t_pwm;
        logic [5:0]  fq [3] = '{6'h11, 6'h3f, 6'h3c};
        logic [2:0]  wv [3] = '{3'h5, 3'h2, 3'h7};
        logic [23:0] s      = 24'h1b1b39;
        logic [11:0] e;
        xfer(1'b1, 5'h18, 8'h39);
        xfer(1'b1, 5'h04, 8'h1b);
        xfer(1'b1, 5'h08, 8'haa);
        check({16'h0, sel14, sel58}, 32'h0000391b);
        foreach (fq[i]) begin
            @(posedge clock_i);
            freq   <= fq[i];
            wave   <= wv[i];
            src912 <= s[23:16];
            repeat (3) @(posedge clock_i);
            @(negedge clock_i);
            for (int b = 0; b < 12; b++) begin
                e[b] = gexp(s[2*b+1 -: 2]);
            end
            check({16'h0, upper, lower, gate},
                  {16'h0, e[11:8], 4'h0, e[7:0]});
        end
    endtask
    task automatic t_read;
        logic [4:0] pa [3] = '{5'h08, 5'h18, 5'h04};
        logic [7:0] ex [3] = '{8'haa, 8'h39, 8'h1b};
        foreach (pa[i]) begin
            xfer(1'b0, pa[i], ~ex[i]);
            check({rx[7:0], sw_en, sel14, sel58},
                  {ex[i], 24'haa391b});
        end
        xfer(1'b1, 5'h1f, 8'h5a);
        xfer(1'b0, 5'h1f, 8'h00);
        check({rx[7:0], sw_en, sel14, sel58}, 32'h00aa391b);
    endtask
    task automatic t_short;
        master.frame({1'b1, 5'h08, 2'h0, 8'h00}, 15, rx);
        xfer(1'b0, 5'h08, 8'h00);
        check({15'h0, rx[8], 8'h0, sw_en}, 32'h000100aa);
        // a good frame clears the bad-frame flag seen by the next one
        xfer(1'b0, 5'h08, 8'h00);
        check({15'h0, rx[8], 8'h0, sw_en}, 32'h000000aa);
    endtask
    initial begin
        t_reset();
        t_enables();
        t_pwm();
        t_read();
        t_short();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
